/* File: bench/pcie_ext_capability_regs_asserts.sv */
// Port checker for the extended capability register bank
`include "ext_cap_cfg.svh"

module pcie_ext_capability_regs_asserts
    import ext_cap_pkg::*;
#(
    parameter bit UPSTREAM_PORT = 1'b1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic warm_reset,
    input wire logic cap_unlock,
    input apb_req_t apb_req,
    input apb_rsp_t apb_rsp,
    input wire logic err_first_report,
    input tlp_header_t err_header,
    input wire logic err_log_rearm,
    input wire logic log_held,
    input wire logic [63:0] unique_id_word
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // A committed write while unlocked is the only cause of a serial number change
    logic wr_commit;
    assign wr_commit = apb_rsp.pready && apb_req.pwrite && cap_unlock;

    // Bus answer timing: one wait state, single-cycle answer
    ready_timing_a: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("pready not exactly one cycle after access start");
    ready_in_access_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
        else $error("pready outside an access phase");
    error_reads_zero_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
        else $error("pslverr without pready or with data");
    write_data_zero_a: assert property (apb_rsp.pready && apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
        else $error("read data not zero on a write");
    vc_word_const_a: assert property (
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr[11:2] == (`OFF_PORT_VC_CAP1 >> 2)
        |-> apb_rsp.prdata == {20'h0, (UPSTREAM_PORT ? 2'h2 : 2'h0), 10'h0})
        else $error("port channel word wrong");
    // Error log holding
    log_capture_a: assert property (err_first_report && (!log_held || err_log_rearm) |=> log_held)
        else $error("first error not captured");
    log_rearm_a: assert property (err_log_rearm && !err_first_report |=> !log_held)
        else $error("rearm did not free the log");
    log_keep_a: assert property (log_held && !err_log_rearm |=> log_held)
        else $error("log released without rearm");
    id_write_only_a: assert property (!$stable(unique_id_word) |-> $past(wr_commit))
        else $error("serial number changed without unlocked write");

    cover property (apb_rsp.pslverr);
    cover property (err_first_report && log_held && err_log_rearm);
    cover property ($rose(warm_reset));
endmodule // pcie_ext_capability_regs_asserts

bind pcie_ext_capability_regs pcie_ext_capability_regs_asserts #(.UPSTREAM_PORT(UPSTREAM_PORT))
    i_pcie_ext_capability_regs_asserts (.clk(clk), .rst_n(rst_n), .warm_reset(warm_reset), .cap_unlock(cap_unlock),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .err_first_report(err_first_report), .err_header(err_header),
    .err_log_rearm(err_log_rearm), .log_held(log_held), .unique_id_word(unique_id_word));

/* File: bench/pcie_ext_capability_regs_test.sv */
// Self-checking bench for the extended capability register bank
`include "ext_cap_cfg.svh"

module pcie_ext_capability_regs_test
    import ext_cap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, warm_reset, cap_unlock, err_first_report, err_log_rearm, log_held;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp, apb_rsp_dn;
    tlp_header_t err_header, hdr;
    logic [63:0] unique_id_word, unique_id_word_dn;
    logic log_held_dn;
    logic [31:0] r1, r2;
    logic [32:0] expect_q[$], expect_dn_q[$];
    int errors, checks_done;
    integer seed = 32'h40284927;

    pcie_ext_capability_regs #(.UPSTREAM_PORT(1'b1)) i_pcie_ext_capability_regs (.clk(clk), .rst_n(rst_n),
        .warm_reset(warm_reset), .cap_unlock(cap_unlock), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .err_first_report(err_first_report), .err_header(err_header), .err_log_rearm(err_log_rearm),
        .log_held(log_held), .unique_id_word(unique_id_word));

    // Downstream twin on the same stimulus; only its entry size field differs
    pcie_ext_capability_regs #(.UPSTREAM_PORT(1'b0)) i_pcie_ext_capability_regs_dn (.clk(clk), .rst_n(rst_n),
        .warm_reset(warm_reset), .cap_unlock(cap_unlock), .apb_req(apb_req), .apb_rsp(apb_rsp_dn),
        .err_first_report(err_first_report), .err_header(err_header), .err_log_rearm(err_log_rearm),
        .log_held(log_held_dn), .unique_id_word(unique_id_word_dn));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic report_and_stop();
        // A note never answered is a lost transfer
        if (expect_q.size() != 0 || expect_dn_q.size() != 0) errors++;
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One access; expected {pslverr, prdata} is queued for the watcher
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
        expect_q.push_back(exp);
        // Downstream port reports 1-bit entries, so bits 11:10 read zero there
        if (!wr && (a[11:2] == (`OFF_PORT_VC_CAP1 >> 2))) expect_dn_q.push_back({exp[32], exp[31:0] & 32'hffff_f3ff});
        else expect_dn_q.push_back(exp);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        @(posedge clk);
        while (apb_rsp.pready !== 1'b1) @(posedge clk);
        apb_req <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, {1'b0, exp});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0);
    endtask

    // Reads every word of the map against the expected picture
    task automatic read_all(input tlp_header_t h, input logic [11:0] sn, input logic [11:0] vn, input logic [63:0] id);
        rd(`OFF_HDR_LOG_W1, h.word1);
        rd(`OFF_HDR_LOG_W2, h.word2);
        rd(`OFF_HDR_LOG_W3, h.word3);
        rd(`OFF_HDR_LOG_W4, h.word4);
        rd(`OFF_SERIAL_CAP, {sn, 4'h1, 16'h0003});
        rd(`OFF_SERIAL_LOW, id[31:0]);
        rd(`OFF_SERIAL_HIGH, id[63:32]);
        rd(`OFF_VC_CAP, {vn, 4'h1, 16'h0002});
        rd(`OFF_PORT_VC_CAP1, 32'h0000_0800);
        chk(unique_id_word, id);
        chk(unique_id_word_dn, id);
    endtask

    // Watcher: every answer takes the oldest note
    always @(posedge clk) begin
        if (rst_n === 1'b1 && apb_rsp.pready === 1'b1) begin
            if (expect_q.size() == 0) chk(64'h1, 64'h0);
            else chk({apb_rsp.pslverr, apb_rsp.prdata}, expect_q.pop_front());
        end
    end

    // Downstream watcher, same scheme on its own note queue
    always @(posedge clk) begin
        if (rst_n === 1'b1 && apb_rsp_dn.pready === 1'b1) begin
            if (expect_dn_q.size() == 0) chk(64'h1, 64'h0);
            else chk({apb_rsp_dn.pslverr, apb_rsp_dn.prdata}, expect_dn_q.pop_front());
        end
    end

    // Watchdog, well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        warm_reset = 1'b0;
        cap_unlock = 1'b0;
        err_first_report = 1'b0;
        err_log_rearm = 1'b0;
        apb_req = '0;
        err_header = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        read_all('0, 12'h200, 12'h000, 64'h0);
        xfer(1'b0, 12'h18c, 32'h0, {1'b1, 32'h0});
        xfer(1'b1, 12'h20c, 32'hffff_ffff, {1'b1, 32'h0});
        r1 = $random(seed);
        r2 = $random(seed);
        // Locked writes must leave everything alone
        wr(`OFF_SERIAL_LOW, r1);
        wr(`OFF_SERIAL_CAP, r2);
        read_all('0, 12'h200, 12'h000, 64'h0);
        cap_unlock <= 1'b1;
        wr(`OFF_SERIAL_LOW, r1);
        wr(`OFF_SERIAL_HIGH, r2);
        wr(`OFF_SERIAL_CAP, r2);
        wr(`OFF_VC_CAP, r1);
        wr(`OFF_PORT_VC_CAP1, r1);
        wr(`OFF_HDR_LOG_W2, r2);
        read_all('0, r2[31:20], r1[31:20], {r2, r1});
        // First error captured, a later one ignored while held
        hdr = {$random(seed), $random(seed), $random(seed), $random(seed)};
        err_first_report <= 1'b1;
        err_header <= hdr;
        @(posedge clk);
        err_first_report <= 1'b0;
        err_header <= ~hdr;
        @(posedge clk);
        chk(log_held, 1);
        err_first_report <= 1'b1;
        @(posedge clk);
        err_first_report <= 1'b0;
        @(posedge clk);
        read_all(hdr, r2[31:20], r1[31:20], {r2, r1});
        // Report and rearm together: the report wins
        err_first_report <= 1'b1;
        err_log_rearm <= 1'b1;
        @(posedge clk);
        err_first_report <= 1'b0;
        err_log_rearm <= 1'b0;
        @(posedge clk);
        chk(log_held, 1);
        read_all(~hdr, r2[31:20], r1[31:20], {r2, r1});
        // Warm reset restores pointers only; sticky words stay
        warm_reset <= 1'b1;
        @(posedge clk);
        warm_reset <= 1'b0;
        @(posedge clk);
        read_all(~hdr, 12'h200, 12'h000, {r2, r1});
        err_log_rearm <= 1'b1;
        @(posedge clk);
        err_log_rearm <= 1'b0;
        @(posedge clk);
        chk(log_held, 0);
        chk(log_held_dn, 0);
        // Power-on reset clears the sticky words as well
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        read_all('0, 12'h200, 12'h000, 64'h0);
        report_and_stop();
    end
endmodule // pcie_ext_capability_regs_test

/* File: rtl/ext_cap_cfg.svh */
// Offsets, field positions, reset values and constants of the extended capability register bank
`ifndef EXT_CAP_CFG_SVH
`define EXT_CAP_CFG_SVH

// ****************************************************************
// Register byte offsets (12-bit configuration space address)
// ****************************************************************
`define OFF_HDR_LOG_W1 12'h11c
`define OFF_HDR_LOG_W2 12'h120
`define OFF_HDR_LOG_W3 12'h124
`define OFF_HDR_LOG_W4 12'h128
`define OFF_SERIAL_CAP 12'h180
`define OFF_SERIAL_LOW 12'h184
`define OFF_SERIAL_HIGH 12'h188
`define OFF_VC_CAP 12'h200
`define OFF_PORT_VC_CAP1 12'h204

// ****************************************************************
// Field positions
// ****************************************************************
`define FLD_CAP_ID 15:0
`define FLD_CAP_VER 19:16
`define FLD_NEXT_PTR 31:20
`define FLD_EXTRA_CNT 2:0
`define FLD_LP_EXTRA_CNT 6:4
`define FLD_ARB_REF_CLOCK 9:8
`define FLD_ENTRY_SIZE 11:10

// ****************************************************************
// Reset and constant field values
// ****************************************************************
`define SERIAL_CAP_ID 16'h0003
`define VC_CAP_ID 16'h0002
`define CAP_VERSION 4'h1
`define SERIAL_NEXT_RST 12'h200
`define VC_NEXT_RST 12'h000
`define EXTRA_CNT_VAL 3'h0
`define LP_EXTRA_CNT_VAL 3'h0
`define ARB_REF_CLOCK_VAL 2'h0
`define ENTRY_1BIT 2'h0
`define ENTRY_2BIT 2'h1
`define ENTRY_4BIT 2'h2
`define ENTRY_8BIT 2'h3
`define SERIAL_RST 32'h0000_0000
`define HDR_LOG_RST 32'h0000_0000
`define WORD_ZERO 32'h0000_0000

`endif

/* File: rtl/ext_cap_pkg.sv */
// Types shared by the extended capability register bank
package ext_cap_pkg;

    // ****************************************************************
    // Bus carriers
    // ****************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // Logged packet header, word1 is the first header doubleword
    typedef struct packed {
        logic [31:0] word1;
        logic [31:0] word2;
        logic [31:0] word3;
        logic [31:0] word4;
    } tlp_header_t;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_ANSWER = 2'b10
    } apb_phase_t;

    typedef struct packed {
        logic held;
        tlp_header_t log;
    } log_state_t;

    typedef struct packed {
        apb_phase_t phase;
        apb_rsp_t rsp;
        logic [11:0] serial_next;
        logic [11:0] vc_next;
        logic [31:0] sn_low;
        logic [31:0] sn_high;
    } bank_state_t;

endpackage

/* File: rtl/header_log_capture.sv */
// Sticky capture of the four header words of the first reported uncorrectable error
`include "ext_cap_cfg.svh"

module header_log_capture
    import ext_cap_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic err_first_report,
    input tlp_header_t err_header,
    input wire logic err_log_rearm,
    output tlp_header_t logged_header_word,
    output logic log_held
);

    log_state_t state_reg;
    log_state_t state_next;

    // ****************************************************************
    // Capture
    // ****************************************************************
    // A new report is taken only while nothing is held; a rearm in the same
    // cycle as a report frees the log and the report wins, so it is not lost.
    always_comb begin
        state_next = state_reg;
        if (err_first_report && (!state_reg.held || err_log_rearm)) begin
            state_next.log = err_header; // All four words together
            state_next.held = 1'b1;
        end else if (err_log_rearm) begin
            state_next.held = 1'b0;
        end
    end

    // Only the power-on reset clears the log; warm resets never reach here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.held <= 1'b0;
            state_reg.log <= {`HDR_LOG_RST, `HDR_LOG_RST, `HDR_LOG_RST, `HDR_LOG_RST};
        end else begin
            state_reg <= state_next;
        end
    end

    assign logged_header_word = state_reg.log;
    assign log_held = state_reg.held;

endmodule // header_log_capture

/* File: rtl/pcie_ext_capability_regs.sv */
// APB register bank for the header log, serial number and virtual channel capability words
//
// Functional notes
// - Header log words two to four are read-only sticky words, reset zero.
// - Serial capability header: identifier 0x3; next pointer 0x200, writable when unlocked.
// - Serial and channel capability headers report version 0x1 in bits 19:16.
// - Serial low word holds identifier bits 31:0; sticky, zero reset, unlock-writable.
// - Serial high word holds identifier bits 63:32; sticky, zero reset, unlock-writable.
// - Channel capability header returns identifier 0x2.
// - Channel capability next pointer defaults to 0x0, ending the chain.
// - Extra channel count bits 2:0 read 0x0.
// - Low priority extra channel count bits 6:4 read 0x0.
// - Arbitration reference clock bits 9:8 read 0x0.
// - Entry size encodes 0 1-bit, 1 2-bit, 2 4-bit, 3 8-bit.
// - Entry size reads 0x2 on the upstream port, 0x0 downstream.
// - First header word is held too; all four words captured together.

`include "ext_cap_cfg.svh"

module pcie_ext_capability_regs
    import ext_cap_pkg::*;
#(
    parameter bit UPSTREAM_PORT = 1'b1
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic warm_reset,
    input wire logic cap_unlock,
    input apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    input wire logic err_first_report,
    input tlp_header_t err_header,
    input wire logic err_log_rearm,
    output logic log_held,
    output logic [63:0] unique_id_word
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Word-aligned address; the two byte bits never select a register
    function automatic logic [11:0] word_addr(input logic [11:0] a);
        return {a[11:2], 2'b00};
    endfunction

    // True for every word this bank answers without an error
    function automatic logic is_mapped(input logic [11:0] a);
        logic [11:0] w;
        w = word_addr(a);
        return (w == `OFF_HDR_LOG_W1) || (w == `OFF_HDR_LOG_W2) ||
               (w == `OFF_HDR_LOG_W3) || (w == `OFF_HDR_LOG_W4) ||
               (w == `OFF_SERIAL_CAP) || (w == `OFF_SERIAL_LOW) ||
               (w == `OFF_SERIAL_HIGH) || (w == `OFF_VC_CAP) ||
               (w == `OFF_PORT_VC_CAP1);
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    bank_state_t state_reg;
    bank_state_t state_next;

    tlp_header_t logged_header_word;
    logic log_held_int;

    logic [1:0] entry_size;
    logic [31:0] serial_hdr_word;
    logic [31:0] vc_hdr_word;
    logic [31:0] port_vc_word;
    logic [31:0] read_word;
    logic [11:0] req_word;
    logic access_done;
    logic write_ok;

    // ****************************************************************
    // Header log
    // ****************************************************************
    // The capture sits apart so its sticky storage never sees warm reset
    header_log_capture u_log (
        .clk(clk),
        .rst_n(rst_n),
        .err_first_report(err_first_report),
        .err_header(err_header),
        .err_log_rearm(err_log_rearm),
        .logged_header_word(logged_header_word),
        .log_held(log_held_int)
    );

    // ****************************************************************
    // Read values of the capability words
    // ****************************************************************
    // Entry size is fixed per port; a strap parameter, not a register
    assign entry_size = UPSTREAM_PORT ? `ENTRY_4BIT : `ENTRY_1BIT;

    // Serial number capability header, all other bits none
    always_comb begin
        serial_hdr_word = `WORD_ZERO;
        serial_hdr_word[`FLD_CAP_ID] = `SERIAL_CAP_ID;
        serial_hdr_word[`FLD_CAP_VER] = `CAP_VERSION;
        serial_hdr_word[`FLD_NEXT_PTR] = state_reg.serial_next;
    end

    // Virtual channel capability header
    always_comb begin
        vc_hdr_word = `WORD_ZERO;
        vc_hdr_word[`FLD_CAP_ID] = `VC_CAP_ID;
        vc_hdr_word[`FLD_CAP_VER] = `CAP_VERSION;
        vc_hdr_word[`FLD_NEXT_PTR] = state_reg.vc_next;
    end

    // First port channel word; bits 3, 7 and 31:12 stay zero
    always_comb begin
        port_vc_word = `WORD_ZERO;
        port_vc_word[`FLD_EXTRA_CNT] = `EXTRA_CNT_VAL;
        port_vc_word[`FLD_LP_EXTRA_CNT] = `LP_EXTRA_CNT_VAL;
        port_vc_word[`FLD_ARB_REF_CLOCK] = `ARB_REF_CLOCK_VAL;
        port_vc_word[`FLD_ENTRY_SIZE] = entry_size;
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    // Unmapped words read zero and are flagged with an error response
    assign req_word = word_addr(apb_req.paddr);

    always_comb begin
        unique case (req_word)
            `OFF_HDR_LOG_W1: read_word = logged_header_word.word1;
            `OFF_HDR_LOG_W2: read_word = logged_header_word.word2;
            `OFF_HDR_LOG_W3: read_word = logged_header_word.word3;
            `OFF_HDR_LOG_W4: read_word = logged_header_word.word4;
            `OFF_SERIAL_CAP: read_word = serial_hdr_word;
            `OFF_SERIAL_LOW: read_word = state_reg.sn_low;
            `OFF_SERIAL_HIGH: read_word = state_reg.sn_high;
            `OFF_VC_CAP: read_word = vc_hdr_word;
            `OFF_PORT_VC_CAP1: read_word = port_vc_word;
            default: read_word = `WORD_ZERO;
        endcase
    end

    // ****************************************************************
    // Bus handshake terms
    // ****************************************************************
    // A transfer completes at the edge where the master sees pready high,
    // which is exactly while this bank sits in the answer phase.
    assign access_done = (state_reg.phase == PH_ANSWER) && apb_req.psel && apb_req.penable;

    // Locked writes are dropped silently; software cannot see the lock here
    assign write_ok = access_done && apb_req.pwrite && cap_unlock && is_mapped(apb_req.paddr);

    // ****************************************************************
    // Next state
    // ****************************************************************
    // One wait state on every access keeps prdata and pready registered.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg.phase)
            PH_IDLE: begin
                state_next.rsp.pready = 1'b0;
                if (apb_req.psel && apb_req.penable) begin
                    state_next.phase = PH_ANSWER;
                    state_next.rsp.pready = 1'b1;
                    state_next.rsp.pslverr = !is_mapped(apb_req.paddr);
                    state_next.rsp.prdata = apb_req.pwrite ? `WORD_ZERO : read_word;
                end
            end
            PH_ANSWER: begin
                // Request is released after this edge, drop the answer
                state_next.phase = PH_IDLE;
                state_next.rsp.pready = 1'b0;
                state_next.rsp.pslverr = 1'b0;
                state_next.rsp.prdata = `WORD_ZERO;
            end
            default: begin
                state_next.phase = PH_IDLE;
                state_next.rsp = '0;
            end
        endcase

        // Register writes; only the defined fields take data
        if (write_ok) begin
            unique case (req_word)
                `OFF_SERIAL_CAP: state_next.serial_next = apb_req.pwdata[`FLD_NEXT_PTR];
                `OFF_SERIAL_LOW: state_next.sn_low = apb_req.pwdata;
                `OFF_SERIAL_HIGH: state_next.sn_high = apb_req.pwdata;
                `OFF_VC_CAP: state_next.vc_next = apb_req.pwdata[`FLD_NEXT_PTR];
                default: begin
                    // Header log and channel word are read-only
                    state_next.serial_next = state_reg.serial_next;
                end
            endcase
        end

        // Warm reset restores the non-sticky pointers only
        if (warm_reset) begin
            state_next.serial_next = `SERIAL_NEXT_RST;
            state_next.vc_next = `VC_NEXT_RST;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // rst_n is the power-on reset and is the only one that clears the
    // serial number; warm_reset leaves sn_low and sn_high untouched.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.phase <= PH_IDLE;
            state_reg.rsp <= '0;
            state_reg.serial_next <= `SERIAL_NEXT_RST;
            state_reg.vc_next <= `VC_NEXT_RST;
            state_reg.sn_low <= `SERIAL_RST;
            state_reg.sn_high <= `SERIAL_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // All outputs are flip-flop values, no logic after the registers
    assign apb_rsp = state_reg.rsp;
    assign log_held = log_held_int;
    assign unique_id_word = {state_reg.sn_high, state_reg.sn_low};

endmodule // pcie_ext_capability_regs
